// ### hdl/sce_params.svh
`ifndef SCE_PARAMS_SVH
`define SCE_PARAMS_SVH

// ==========================================================================
// Socket register offsets within one socket block
`define SCE_OFS_PROTOCOL 16'h0000
`define SCE_OFS_COMMAND 16'h0001
`define SCE_OFS_FLAGS 16'h0002
`define SCE_OFS_STATE 16'h0003

// ==========================================================================
// Reset values
`define SCE_RST_PROTOCOL 8'h00
`define SCE_RST_COMMAND 8'h00
`define SCE_RST_FLAGS 8'h00
`define SCE_RST_STATE 8'h00

// ==========================================================================
// Command codes
`define SCE_CMD_NONE 8'h00
`define SCE_CMD_OPEN 8'h01
`define SCE_CMD_AWAIT 8'h02
`define SCE_CMD_CONNECT 8'h04
`define SCE_CMD_GRACEFUL 8'h08
`define SCE_CMD_CLOSE 8'h10
`define SCE_CMD_SEND 8'h20
`define SCE_CMD_SEND_NORES 8'h21
`define SCE_CMD_KEEPALIVE 8'h22
`define SCE_CMD_RX_CONSUME 8'h40

// ==========================================================================
// Socket state codes
`define SCE_ST_RELEASED 8'h00
`define SCE_ST_TCP_OPEN 8'h13
`define SCE_ST_AWAIT 8'h14
`define SCE_ST_SYN_SENT 8'h15
`define SCE_ST_CONNECTED 8'h17
`define SCE_ST_HALF_CLOSED 8'h1C
`define SCE_ST_FIN_WAIT 8'h18
`define SCE_ST_DATAGRAM 8'h22
`define SCE_ST_RAW_FRAME 8'h42

// ==========================================================================
// Protocol field codes, field in bits 3:0
`define SCE_PROTO_MSB 3
`define SCE_PROTO_CLOSED 4'h0
`define SCE_PROTO_TCP 4'h1
`define SCE_PROTO_UDP 4'h2
`define SCE_PROTO_RAW 4'h4

// ==========================================================================
// Event flag bit positions and implemented mask
`define SCE_FLAG_CONNECTED 0
`define SCE_FLAG_PEER_FIN 1
`define SCE_FLAG_DATA_RX 2
`define SCE_FLAG_TIMEOUT 3
`define SCE_FLAG_SEND_OK 4
`define SCE_FLAG_MASK 8'h1F

// ==========================================================================
// Socket count
`define SCE_NUM_SOCKETS 8

`endif

// ### hdl/sce_pkg.sv
// ==========================================================================
// Shared types of the socket command executor
package sce_pkg;

    // Events reported by the protocol engines
    typedef enum logic [3:0] {
        EVT_CONN_OK,
        EVT_CONN_FAIL,
        EVT_RES_TIMEOUT,
        EVT_TCP_TIMEOUT,
        EVT_KEEP_TIMEOUT,
        EVT_FIN_ACK,
        EVT_PEER_FIN,
        EVT_PEER_RST,
        EVT_SEND_DONE,
        EVT_DATA_RX
    } sce_evt_type;

endpackage

// ### hdl/sce_socket_command_executor.sv
`timescale 1ns/1ps
`include "sce_params.svh"
// How it works
// - Accepted command clears its register to zero
// - Zero command means accepted, not finished
// - Open: TCP to 0x13, UDP to 0x22
// - Raw-frame open only on socket zero
// - Await-peer from TCP-opened, TCP mode only
// - Await-peer: success connects, failure releases
// - Connect sends SYN to configured peer
// - Connect success: connected, event bit 0
// - Connect timeouts: event bit 3, released
// - Graceful disconnect sends FIN, TCP only
// - FIN/ACK releases; missing FIN/ACK times out
// - Close releases at once, no exchange
// - Peer reset releases the socket unless a same-cycle command sets another state
// - Send transmits all pending transmit data
// - Send without resolution, UDP only
// - Keep-alive probe, timeout terminates connection
// - Receive-complete releases consumed receive space
// - Eight sockets chosen by socket select
module sce_socket_command_executor
    import sce_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Host register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [2:0] socket_select,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Requests to the protocol engines
    output logic engReqValid,
    output logic [2:0] engReqSocket,
    output logic [7:0] engReqCode,
    // Events from the protocol engines
    input wire logic engEvtValid,
    input wire logic [2:0] engEvtSocket,
    input wire sce_evt_type engEvtKind
);

    // ======================================================================
    // Default clocking for the checks below
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ======================================================================
    // Per-socket register storage
    logic [7:0] socket_protocol_reg [`SCE_NUM_SOCKETS]; // Mode, host owned
    logic [7:0] socket_command_reg [`SCE_NUM_SOCKETS]; // Self-clearing
    logic [7:0] socket_event_flags_reg [`SCE_NUM_SOCKETS]; // Sticky events
    logic [7:0] socket_state_reg [`SCE_NUM_SOCKETS]; // Read-only state
    logic [`SCE_NUM_SOCKETS-1:0] reqFire; // Socket hands work on

    // ======================================================================
    // One socket slice per generate pass
    for (genvar i = 0; i < `SCE_NUM_SOCKETS; i++) begin : g_sock
        logic hostHit; // Host write aimed at this socket
        logic evtHit; // Engine event aimed at this socket
        logic [3:0] proto; // Protocol field
        logic isTcp;
        logic [7:0] protoNext;
        logic [7:0] cmdNext;
        logic [7:0] flagsNext;
        logic [7:0] stateNext;
        logic [7:0] setBits; // Hardware set requests
        logic [7:0] clrBits; // Host write-one-to-clear
        logic fireNext;

        assign hostHit = regWrEn && (socket_select == 3'(i));
        assign evtHit = engEvtValid && (engEvtSocket == 3'(i));
        assign proto = socket_protocol_reg[i][`SCE_PROTO_MSB:0];
        assign isTcp = (proto == `SCE_PROTO_TCP);

        // Next values: events first, then command, then host writes
        always_comb begin
            protoNext = socket_protocol_reg[i];
            cmdNext = socket_command_reg[i];
            stateNext = socket_state_reg[i];
            setBits = 8'h00;
            clrBits = 8'h00;
            fireNext = 1'b0;
            // Engine events
            if (evtHit) begin
                case (engEvtKind)
                    EVT_CONN_OK: begin
                        if (socket_state_reg[i] == `SCE_ST_AWAIT ||
                            socket_state_reg[i] == `SCE_ST_SYN_SENT) begin
                            stateNext = `SCE_ST_CONNECTED;
                            setBits[`SCE_FLAG_CONNECTED] = 1'b1;
                        end
                    end
                    EVT_CONN_FAIL, EVT_RES_TIMEOUT, EVT_TCP_TIMEOUT,
                    EVT_KEEP_TIMEOUT: begin
                        // Timeout flag rises with the release
                        setBits[`SCE_FLAG_TIMEOUT] = 1'b1;
                        stateNext = `SCE_ST_RELEASED;
                    end
                    EVT_FIN_ACK: begin
                        setBits[`SCE_FLAG_PEER_FIN] = 1'b1;
                        if (socket_state_reg[i] == `SCE_ST_FIN_WAIT) begin
                            stateNext = `SCE_ST_RELEASED;
                        end
                    end
                    EVT_PEER_FIN: begin
                        setBits[`SCE_FLAG_PEER_FIN] = 1'b1;
                        if (socket_state_reg[i] == `SCE_ST_CONNECTED) begin
                            stateNext = `SCE_ST_HALF_CLOSED;
                        end
                    end
                    EVT_PEER_RST: stateNext = `SCE_ST_RELEASED;
                    EVT_SEND_DONE: setBits[`SCE_FLAG_SEND_OK] = 1'b1;
                    EVT_DATA_RX: setBits[`SCE_FLAG_DATA_RX] = 1'b1;
                    default: ;
                endcase
            end
            // Pending command: decoded once, then cleared
            if (socket_command_reg[i] != `SCE_CMD_NONE) begin
                cmdNext = `SCE_CMD_NONE;
                case (socket_command_reg[i])
                    `SCE_CMD_OPEN: begin
                        if (isTcp) begin
                            stateNext = `SCE_ST_TCP_OPEN;
                            fireNext = 1'b1;
                        end else if (proto == `SCE_PROTO_UDP) begin
                            stateNext = `SCE_ST_DATAGRAM;
                            fireNext = 1'b1;
                        end else if (proto == `SCE_PROTO_RAW && i == 0) begin
                            stateNext = `SCE_ST_RAW_FRAME;
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_AWAIT: begin
                        if (isTcp &&
                            socket_state_reg[i] == `SCE_ST_TCP_OPEN) begin
                            stateNext = `SCE_ST_AWAIT;
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_CONNECT: begin
                        // Engine takes peer address and port itself
                        if (isTcp &&
                            socket_state_reg[i] == `SCE_ST_TCP_OPEN) begin
                            stateNext = `SCE_ST_SYN_SENT;
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_GRACEFUL: begin
                        // Active close from connected, passive from half
                        if (isTcp &&
                            (socket_state_reg[i] == `SCE_ST_CONNECTED ||
                            socket_state_reg[i] == `SCE_ST_HALF_CLOSED)) begin
                            stateNext = `SCE_ST_FIN_WAIT;
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_CLOSE: begin
                        // Engine is told so it drops the socket silently
                        stateNext = `SCE_ST_RELEASED;
                        fireNext = 1'b1;
                    end
                    `SCE_CMD_SEND: begin
                        if (socket_state_reg[i] == `SCE_ST_CONNECTED ||
                            socket_state_reg[i] == `SCE_ST_HALF_CLOSED ||
                            socket_state_reg[i] == `SCE_ST_DATAGRAM ||
                            socket_state_reg[i] == `SCE_ST_RAW_FRAME) begin
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_SEND_NORES: begin
                        if (proto == `SCE_PROTO_UDP &&
                            socket_state_reg[i] == `SCE_ST_DATAGRAM) begin
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_KEEPALIVE: begin
                        if (isTcp &&
                            socket_state_reg[i] == `SCE_ST_CONNECTED) begin
                            fireNext = 1'b1;
                        end
                    end
                    `SCE_CMD_RX_CONSUME: begin
                        if (socket_state_reg[i] != `SCE_ST_RELEASED) begin
                            fireNext = 1'b1;
                        end
                    end
                    default: ; // Unknown code only cleared
                endcase
                // Invalid combinations fall through untouched
            end
            // Host writes
            if (hostHit) begin
                case (regAddr)
                    `SCE_OFS_PROTOCOL: protoNext = regWrData;
                    `SCE_OFS_COMMAND: begin
                        // Busy register ignores a second write
                        if (socket_command_reg[i] == `SCE_CMD_NONE) begin
                            cmdNext = regWrData;
                        end
                    end
                    `SCE_OFS_FLAGS: clrBits = regWrData;
                    default: ;
                endcase
            end
            // Set beats a same-cycle clear
            flagsNext = ((socket_event_flags_reg[i] & ~clrBits) | setBits)
                & `SCE_FLAG_MASK;
        end

        // Registering of the socket slice
        always_ff @(posedge clk) begin
            if (srst) begin
                socket_protocol_reg[i] <= `SCE_RST_PROTOCOL;
                socket_command_reg[i] <= `SCE_RST_COMMAND;
                socket_event_flags_reg[i] <= `SCE_RST_FLAGS;
                socket_state_reg[i] <= `SCE_RST_STATE;
                reqFire[i] <= 1'b0;
            end else if (ce) begin
                socket_protocol_reg[i] <= protoNext;
                socket_command_reg[i] <= cmdNext;
                socket_event_flags_reg[i] <= flagsNext;
                socket_state_reg[i] <= stateNext;
                reqFire[i] <= fireNext;
            end
        end

        // ==================================================================
        // Checks on this socket
        cmd_self_clear_a: assert property (
            ce && socket_command_reg[i] != 8'h00
            |=> socket_command_reg[i] == 8'h00)
            else $error("command register not cleared");
        open_tcp_state_a: assert property (
            ce && socket_command_reg[i] == `SCE_CMD_OPEN && isTcp
            |=> socket_state_reg[i] == 8'h13 ##0 reqFire[i])
            else $error("tcp open did not reach opened state");
        open_raw_state_a: assert property (
            ce && socket_command_reg[i] == `SCE_CMD_OPEN &&
            proto == `SCE_PROTO_RAW
            |=> socket_state_reg[i] == ((i == 0) ? 8'h42 :
                $past(socket_state_reg[i])))
            else $error("raw open state wrong");
        await_move_a: assert property (
            ce && socket_command_reg[i] == `SCE_CMD_AWAIT &&
            isTcp && socket_state_reg[i] == `SCE_ST_TCP_OPEN
            |=> socket_state_reg[i] == `SCE_ST_AWAIT)
            else $error("await command did not move state");
        conn_ok_flag_a: assert property (
            ce && evtHit && engEvtKind == EVT_CONN_OK &&
            socket_command_reg[i] == 8'h00 &&
            socket_state_reg[i] == `SCE_ST_SYN_SENT
            |=> socket_state_reg[i] == `SCE_ST_CONNECTED &&
            socket_event_flags_reg[i][0])
            else $error("connect success not reported");
        timeout_release_a: assert property (
            ce && evtHit && socket_command_reg[i] == 8'h00 &&
            (engEvtKind == EVT_RES_TIMEOUT || engEvtKind == EVT_TCP_TIMEOUT)
            |=> socket_state_reg[i] == 8'h00 &&
            socket_event_flags_reg[i][3])
            else $error("timeout did not release socket");
        close_release_a: assert property (
            ce && socket_command_reg[i] == `SCE_CMD_CLOSE
            |=> socket_state_reg[i] == 8'h00)
            else $error("close did not release socket");
        reset_release_a: assert property (
            ce && evtHit && engEvtKind == EVT_PEER_RST &&
            socket_command_reg[i] == 8'h00
            |=> socket_state_reg[i] == 8'h00)
            else $error("peer reset did not release socket");
        invalid_keep_a: assert property (
            ce && !evtHit && !isTcp &&
            socket_command_reg[i] == `SCE_CMD_KEEPALIVE
            |=> $stable(socket_state_reg[i]) && !reqFire[i])
            else $error("invalid command changed state");
        flag_set_wins_a: assert property (
            ce && evtHit && engEvtKind == EVT_SEND_DONE && hostHit &&
            regAddr == `SCE_OFS_FLAGS
            |=> socket_event_flags_reg[i][`SCE_FLAG_SEND_OK])
            else $error("event lost against clear");
        open_cover_c: cover property (
            socket_command_reg[i] == `SCE_CMD_OPEN ##1
            socket_state_reg[i] == `SCE_ST_TCP_OPEN);
        connect_cover_c: cover property (
            socket_state_reg[i] == `SCE_ST_SYN_SENT ##[1:50]
            socket_state_reg[i] == `SCE_ST_CONNECTED);
        graceful_cover_c: cover property (
            socket_state_reg[i] == `SCE_ST_FIN_WAIT ##[1:50]
            socket_state_reg[i] == `SCE_ST_RELEASED);
    end

    // ======================================================================
    // Engine request and read-back registers
    logic engReqValid_reg;
    logic [2:0] engReqSocket_reg;
    logic [7:0] engReqCode_reg;
    logic [7:0] lastCmd_reg [`SCE_NUM_SOCKETS]; // Code behind a request
    logic engReqValid_next;
    logic [2:0] engReqSocket_next;
    logic [7:0] engReqCode_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;

    // Codes accepted last cycle, kept for the request word
    always_ff @(posedge clk) begin
        for (int k = 0; k < `SCE_NUM_SOCKETS; k++) begin
            if (srst) begin
                lastCmd_reg[k] <= 8'h00;
            end else if (ce) begin
                lastCmd_reg[k] <= socket_command_reg[k];
            end
        end
    end

    // Only one socket can fire per cycle, as host writes are serial
    always_comb begin
        engReqValid_next = 1'b0;
        engReqSocket_next = 3'h0;
        engReqCode_next = 8'h00;
        for (int k = `SCE_NUM_SOCKETS - 1; k >= 0; k--) begin
            if (reqFire[k]) begin
                engReqValid_next = 1'b1;
                engReqSocket_next = 3'(k);
                engReqCode_next = lastCmd_reg[k];
            end
        end
    end

    // Read data, unmapped offsets answer zero
    always_comb begin
        rdData_next = rdData_reg;
        if (regRdEn) begin
            case (regAddr)
                `SCE_OFS_PROTOCOL: rdData_next =
                    socket_protocol_reg[socket_select];
                `SCE_OFS_COMMAND: rdData_next =
                    socket_command_reg[socket_select];
                `SCE_OFS_FLAGS: rdData_next =
                    socket_event_flags_reg[socket_select];
                `SCE_OFS_STATE: rdData_next =
                    socket_state_reg[socket_select];
                default: rdData_next = 8'h00;
            endcase
        end
    end

    // Output registers
    always_ff @(posedge clk) begin
        if (srst) begin
            engReqValid_reg <= 1'b0;
            engReqSocket_reg <= 3'h0;
            engReqCode_reg <= 8'h00;
            rdData_reg <= 8'h00;
        end else if (ce) begin
            engReqValid_reg <= engReqValid_next;
            engReqSocket_reg <= engReqSocket_next;
            engReqCode_reg <= engReqCode_next;
            rdData_reg <= rdData_next;
        end
    end

    assign engReqValid = engReqValid_reg;
    assign engReqSocket = engReqSocket_reg;
    assign engReqCode = engReqCode_reg;
    assign regRdData = rdData_reg;

    req_cover_c: cover property (engReqValid_reg &&
        engReqCode_reg == `SCE_CMD_SEND);

endmodule

// ### tb/sce_engine_model.sv
`timescale 1ns/1ps
// ==========================================================
// Protocol engine stand-in: answers requests after a delay
module sce_engine_model
    import sce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Requests seen from the executor
    input wire logic reqValid,
    input wire logic [2:0] reqSocket,
    input wire logic [7:0] reqCode,
    // Bench control: answer kind, delay, unsolicited kick
    input wire sce_evt_type armKind,
    input wire logic [7:0] armDelay,
    input wire logic kick,
    input wire logic [2:0] kickSocket,
    // Events toward the executor
    output logic evtValid,
    output logic [2:0] evtSocket,
    output sce_evt_type evtKind
);
    logic [7:0] cnt; // Cycles left before the answer, zero when idle
    logic [2:0] sock; // Socket waiting for its outcome
    // Mask 0x2E picks listen, connect, disconnect, sends, keep-alive;
    // open, close and receive-complete end without an engine outcome
    always @(posedge clk) begin
        if (srst) begin
            cnt <= #1 8'h00;
            evtValid <= #1 1'b0;
            evtSocket <= #1 3'h0;
            evtKind <= #1 EVT_CONN_OK;
        end else begin
            evtValid <= #1 kick || cnt == 8'h01;
            if (kick) begin
                evtSocket <= #1 kickSocket;
                evtKind <= #1 armKind;
            end else if (cnt == 8'h01) begin
                evtSocket <= #1 sock;
                evtKind <= #1 armKind;
            end else begin
                // Idle lines wander so a stale value is never trusted
                evtSocket <= #1 ~evtSocket;
                evtKind <= #1 sce_evt_type'(cnt[3:0]);
            end
            if (reqValid && (reqCode & 8'h2E) != 8'h00) begin
                cnt <= #1 armDelay;
                sock <= #1 reqSocket;
            end else if (cnt != 8'h00) begin
                cnt <= #1 cnt - 8'h01;
            end
        end
    end
endmodule

// ### tb/tb_socket_command_executor.sv
`timescale 1ns/1ps
`include "sce_params.svh"
module tb_socket_command_executor
    import sce_pkg::*;
;
    // ==========================================================
    // Stimulus and observation
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
    logic regWrEn = 1'b0, regRdEn = 1'b0, kick = 1'b0;
    logic [2:0] sel = 3'h0, kickSocket = 3'h0, engReqSocket, lastSock;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, engReqCode, lastCode, n, v;
    logic [7:0] armDelay = 8'h01, reqCnt = 8'h00;
    logic engReqValid, evtValid;
    logic [2:0] evtSocket;
    sce_evt_type evtKind, armKind = EVT_CONN_OK;
    int failCount = 0, testsRun = 0;
    // Open table: socket, protocol field, expected state
    logic [2:0] os [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h4};
    logic [3:0] op [5] = '{4'h4, 4'h2, 4'h0, 4'h4, 4'h2};
    logic [7:0] oe [5] = '{8'h42, 8'h22, 8'h00, 8'h00, 8'h22};
    sce_evt_type fk [3] = '{EVT_RES_TIMEOUT, EVT_TCP_TIMEOUT, EVT_CONN_FAIL};

    initial begin
        forever #2.5 clk = ~clk;
    end

    sce_socket_command_executor dut (.clk(clk), .srst(srst), .ce(ce),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .socket_select(sel),
        .regAddr(addr), .regWrData(wdata), .regRdData(rdata),
        .engReqValid(engReqValid), .engReqSocket(engReqSocket),
        .engReqCode(engReqCode), .engEvtValid(evtValid),
        .engEvtSocket(evtSocket), .engEvtKind(evtKind));

    sce_engine_model eng (.clk(clk), .srst(srst), .reqValid(engReqValid),
        .reqSocket(engReqSocket), .reqCode(engReqCode), .armKind(armKind),
        .armDelay(armDelay), .kick(kick), .kickSocket(kickSocket),
        .evtValid(evtValid), .evtSocket(evtSocket), .evtKind(evtKind));

    // Engine requests are one-cycle pulses, so count them at the edge
    always @(posedge clk) begin
        if (engReqValid === 1'b1) begin
            reqCnt <= reqCnt + 8'h01;
            lastCode <= engReqCode;
            lastSock <= engReqSocket;
        end
    end

    // ==========================================================
    // Access tasks
    task automatic chk(input string what, input logic [7:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [15:0] a,
                      input logic [7:0] d);
        @(posedge clk); #1;
        sel = s; addr = a; wdata = d; regWrEn = 1'b1;
        @(posedge clk); #1;
        regWrEn = 1'b0;
    endtask
    // Extra edge: read data is registered one cycle late
    task automatic chkr(input string what, input logic [2:0] s,
                        input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk); #1;
        sel = s; addr = a; regRdEn = 1'b1;
        @(posedge clk); #1;
        regRdEn = 1'b0;
        @(posedge clk); #1;
        chk(what, rdata, exp);
    endtask
    // Arm the engine answer, issue a command, let it play out
    task automatic cmd(input logic [2:0] s, input logic [7:0] c,
                       input sce_evt_type k, input logic [7:0] dly);
        armKind = k; armDelay = dly;
        wr(s, 16'h0001, c);
        repeat (dly + 4) @(posedge clk);
    endtask
    // Check state and flags, then clear flags by writing ones
    task automatic st(input logic [2:0] s, input logic [7:0] es, ef);
        chkr("state", s, 16'h0003, es);
        chkr("flags", s, 16'h0002, ef);
        wr(s, 16'h0002, 8'hFF);
    endtask
    // Open as TCP and connect; k is the engine's connect outcome
    task automatic up(input logic [2:0] s,
                      input sce_evt_type k = EVT_CONN_OK);
        wr(s, 16'h0000, 8'h01);
        cmd(s, `SCE_CMD_OPEN, EVT_CONN_OK, 8'h01);
        cmd(s, `SCE_CMD_CONNECT, k, 8'h03);
    endtask
    // Kick an event; a flags clear with mask clr lands on the same edge
    task automatic hit(input logic [2:0] s, input sce_evt_type k,
                       input logic [7:0] clr = 8'h00);
        @(posedge clk); #1;
        armKind = k; kickSocket = s; kick = 1'b1;
        @(posedge clk); #1;
        kick = 1'b0;
        sel = s;
        addr = 16'h0002;
        wdata = clr;
        regWrEn = 1'b1;
        @(posedge clk); #1;
        regWrEn = 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; allow far more
    initial begin
        #100000;
        failCount++;
        wrapUp();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            chkr("reset", 3'h5, 16'(i), 8'h00);
        end
        for (int i = 0; i < 5; i++) begin
            n = reqCnt;
            wr(os[i], 16'h0000, {4'h0, op[i]});
            cmd(os[i], `SCE_CMD_OPEN, EVT_CONN_OK, 8'h01);
            chk("openreq", reqCnt - n, {7'h00, oe[i] != 8'h00});
            chkr("cmdclr", os[i], 16'h0001, 8'h00);
            st(os[i], oe[i], 8'h00);
        end
        // Datagram socket: refused listen, send without resolution
        n = reqCnt;
        cmd(3'h1, `SCE_CMD_AWAIT, EVT_CONN_OK, 8'h02);
        cmd(3'h1, `SCE_CMD_KEEPALIVE, EVT_CONN_OK, 8'h01);
        wr(3'h1, 16'h0003, 8'hFF);
        chk("badreq", reqCnt - n, 8'h00);
        st(3'h1, 8'h22, 8'h00);
        cmd(3'h1, `SCE_CMD_SEND_NORES, EVT_SEND_DONE, 8'h02);
        chk("noresreq", lastCode, 8'h21);
        st(3'h1, 8'h22, 8'h10);
        cmd(3'h4, `SCE_CMD_RX_CONSUME, EVT_CONN_OK, 8'h01);
        chk("rxreq", {5'h00, lastSock}, 8'h04);
        chk("rxcode", lastCode, 8'h40);
        hit(3'h4, EVT_PEER_RST);
        st(3'h4, 8'h00, 8'h00);
        // Client connect, then its failure outcomes
        up(3'h3);
        chk("conncode", lastCode, 8'h04);
        st(3'h3, 8'h17, 8'h01);
        for (int i = 0; i < 3; i++) begin
            up(3'h5, fk[i]);
            st(3'h5, 8'h00, 8'h08);
        end
        // Server side, slow peer so the wait is visible
        wr(3'h7, 16'h0000, 8'h01);
        cmd(3'h7, `SCE_CMD_OPEN, EVT_CONN_OK, 8'h01);
        armKind = EVT_CONN_OK; armDelay = 8'h28;
        wr(3'h7, 16'h0001, `SCE_CMD_AWAIT);
        chkr("await", 3'h7, 16'h0003, 8'h14);
        chkr("busy", 3'h7, 16'h0001, 8'h00);
        repeat (40) @(posedge clk);
        st(3'h7, 8'h17, 8'h01);
        wr(3'h2, 16'h0000, 8'h01);
        cmd(3'h2, `SCE_CMD_OPEN, EVT_CONN_OK, 8'h01);
        cmd(3'h2, `SCE_CMD_AWAIT, EVT_CONN_FAIL, 8'h05);
        st(3'h2, 8'h00, 8'h08);
        // Traffic on a live connection
        n = reqCnt;
        cmd(3'h3, `SCE_CMD_SEND_NORES, EVT_CONN_OK, 8'h01);
        chk("tcpnores", reqCnt - n, 8'h00);
        cmd(3'h3, `SCE_CMD_SEND, EVT_SEND_DONE, 8'h04);
        chk("sendcode", lastCode, 8'h20);
        st(3'h3, 8'h17, 8'h10);
        // Send-done event against a same-edge clear: the set must win
        hit(3'h3, EVT_SEND_DONE, 8'h10);
        st(3'h3, 8'h17, 8'h10);
        cmd(3'h3, `SCE_CMD_KEEPALIVE, EVT_KEEP_TIMEOUT, 8'h06);
        chk("keepcode", lastCode, 8'h22);
        st(3'h3, 8'h00, 8'h08);
        // Disconnects: answered, unanswered, peer half-close then close
        cmd(3'h7, `SCE_CMD_GRACEFUL, EVT_FIN_ACK, 8'h04);
        chk("fincode", lastCode, 8'h08);
        st(3'h7, 8'h00, 8'h02);
        up(3'h3);
        cmd(3'h3, `SCE_CMD_GRACEFUL, EVT_TCP_TIMEOUT, 8'h04);
        st(3'h3, 8'h00, 8'h09);
        up(3'h3);
        hit(3'h3, EVT_PEER_FIN);
        st(3'h3, 8'h1C, 8'h03);
        cmd(3'h3, `SCE_CMD_CLOSE, EVT_CONN_OK, 8'h01);
        chk("closecode", lastCode, 8'h10);
        st(3'h3, 8'h00, 8'h00);
        up(3'h6);
        hit(3'h6, EVT_PEER_RST);
        st(3'h6, 8'h00, 8'h01);
        wrapUp();
    end
endmodule
